// file: hw/energy_meter_pulse_backend.sv
// metering back end: tamper select, offsets, pulses, events, registers
`timescale 1ns/100ps
module energy_meter_pulse_backend #(
  parameter int unsigned PULSE_CYCLES = emu_pkg::PULSE_CYC,
  parameter int unsigned AUTO_DC_TRIGGER_CYCLES = emu_pkg::DC_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [23:0] reg_rdata,
  input wire logic [15:0] raw_i1,
  input wire logic [15:0] raw_i2,
  input wire logic [15:0] raw_u,
  input wire logic sample_valid,
  input wire logic [23:0] rms_i1,
  input wire logic [23:0] rms_i2,
  input wire logic [23:0] power_p,
  input wire logic [23:0] power_q,
  input wire logic [2:0] ovf_valid,
  input wire logic [2:0] ovf_neg,
  output logic active_pulse_out,
  output logic reactive_pulse_out,
  output logic apparent_pulse_out,
  output logic irq,
  output logic current_channel_out,
  output logic current_sum_out,
  output logic second_current_converter_on,
  output logic [15:0] current2_gain_trim,
  output logic [2:0] filter_bypass_out
);
  typedef enum logic [1:0] {
    DC_IDLE = 2'b00,
    DC_SUM = 2'b01,
    DC_WAIT = 2'b10
  } dc_state_t;

  function automatic logic [23:0] mag24(input logic [23:0] v);
    mag24 = v[23] ? 24'(-v) : v;
  endfunction

  localparam int DC_LOG2_W = emu_pkg::DC_LOG2 + 1;

  logic [15:0] start_r;
  logic [15:0] hf_r;
  logic [15:0] ratio_r;
  logic [15:0] mincur_r;
  logic [15:0] off_r [3];
  logic [7:0] filt_r;
  logic [7:0] mode_r;
  logic [7:0] adcctl_r;
  logic [7:0] dctrig_r;
  logic [7:0] ev_en_r;
  logic [7:0] ev_flag_r;
  logic [23:0] energy_r [3];
  logic [15:0] samp_w [3];
  logic [15:0] raw_a [3];
  logic [3:0] status_r;
  logic conv_on_r;
  logic sel_r;
  logic sum_r;
  logic theft_detected_r;
  logic gt_r;
  logic auto_on;
  logic wr_ok;
  logic [23:0] abs_p;
  logic [23:0] abs_q;
  logic [23:0] dif;
  logic [39:0] lim;
  logic below_min;
  logic tamper;
  logic [2:0] run;
  logic [2:0] gate;
  logic [7:0] ev_set;
  logic [7:0] ev_nxt;
  logic [23:0] rd_nxt;
  dc_state_t dc_state_r;
  logic [31:0] dc_tmr_r;
  logic [DC_LOG2_W-1:0] dc_cnt_r;
  logic signed [31:0] dc_sum_r [3];
  logic samp_v_r;
  logic u_neg_r;
  logic zx_ev;

  assign auto_on = filt_r[emu_pkg::B_FI_AUTO];
  assign wr_ok = reg_wr;
  assign raw_a[0] = raw_i1;
  assign raw_a[1] = raw_i2;
  assign raw_a[2] = raw_u;

  // ----------------------------------------------------------------
  // no-load and tamper comparisons
  // ----------------------------------------------------------------
  always_comb begin
    abs_p = mag24(power_p);
    abs_q = mag24(power_q);
    dif = (rms_i1 > rms_i2) ? rms_i1 - rms_i2 : rms_i2 - rms_i1;
    lim = ratio_r * ((rms_i1 > rms_i2) ? rms_i1 : rms_i2);
    below_min = (rms_i1 < {8'h00, mincur_r}) &&
      (rms_i2 < {8'h00, mincur_r});
    tamper = !below_min && ({8'h00, dif, 8'h00} >= lim);
    run = mode_r[2:0];
    gate[0] = run[0] && (abs_p >= {8'h00, start_r});
    gate[1] = run[1] && (abs_q >= {8'h00, start_r});
    // apparent is only held back when both powers are small
    gate[2] = run[2] && !((abs_p < {8'h00, start_r}) &&
      (abs_q < {8'h00, start_r}));
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      theft_detected_r <= 1'b0;
      gt_r <= 1'b0;
    end else begin
      theft_detected_r <= tamper;
      gt_r <= !(rms_i1 > rms_i2);
    end
  end

  // ----------------------------------------------------------------
  // channel control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_on_r <= 1'b0;
      sel_r <= 1'b0;
      sum_r <= 1'b0;
    end else begin
      if (wr_ok && reg_addr == emu_pkg::A_CHCTL) begin
        conv_on_r <= reg_wdata[emu_pkg::B_CH_CONV];
      end
      if (auto_on) begin
        sel_r <= tamper && !below_min && (rms_i2 > rms_i1);
      end else if (wr_ok && reg_addr == emu_pkg::A_CHCTL) begin
        sel_r <= reg_wdata[emu_pkg::B_CH_SEL];
        sum_r <= reg_wdata[emu_pkg::B_CH_SUM];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      current_channel_out <= 1'b0;
      current_sum_out <= 1'b0;
      second_current_converter_on <= 1'b0;
      filter_bypass_out <= 3'h0;
    end else begin
      current_channel_out <= sel_r;
      current_sum_out <= sum_r;
      second_current_converter_on <= conv_on_r;
      filter_bypass_out <= filt_r[2:0];
    end
  end

  // ----------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_r <= emu_pkg::RST_WORD;
      hf_r <= emu_pkg::RST_WORD;
      ratio_r <= emu_pkg::RST_WORD;
      mincur_r <= emu_pkg::RST_WORD;
      current2_gain_trim <= emu_pkg::RST_WORD;
      filt_r <= emu_pkg::RST_BYTE;
      mode_r <= emu_pkg::RST_BYTE;
      adcctl_r <= emu_pkg::RST_BYTE;
      ev_en_r <= emu_pkg::RST_BYTE;
    end else if (wr_ok) begin
      unique case (reg_addr)
        emu_pkg::A_START: start_r <= reg_wdata;
        emu_pkg::A_PULSE_DIVIDER_CONSTANT: hf_r <= reg_wdata;
        emu_pkg::A_RATIO: ratio_r <= reg_wdata;
        emu_pkg::A_MINCUR: mincur_r <= reg_wdata;
        emu_pkg::A_CURRENT2_GAIN_TRIM: current2_gain_trim <= reg_wdata;
        emu_pkg::A_FILT: filt_r <= reg_wdata[7:0];
        emu_pkg::A_MODE: mode_r <= reg_wdata[7:0];
        emu_pkg::A_ADCCTL: adcctl_r <= reg_wdata[7:0];
        emu_pkg::A_EV_EN: ev_en_r <= {reg_wdata[7:3], 3'h0};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // high-pass filter or offset correction per channel
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_chan
    logic [23:0] dc_r;
    logic [15:0] samp_r;
    logic [23:0] x_ext;
    assign x_ext = {{8{raw_a[g][15]}}, raw_a[g]};
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        dc_r <= 24'h000000;
        samp_r <= emu_pkg::RST_WORD;
      end else if (sample_valid) begin
        // dc_r holds the running mean scaled up by the filter shift
        dc_r <= dc_r + x_ext - 24'($signed(dc_r) >>> emu_pkg::HPF_SHIFT);
        if (filt_r[g]) begin
          samp_r <= raw_a[g] + off_r[g];
        end else begin
          samp_r <= raw_a[g] - dc_r[23:8];
        end
      end
    end
    assign samp_w[g] = samp_r;
  end

  // ----------------------------------------------------------------
  // automatic offset calibration
  // ----------------------------------------------------------------
  // offsets are the negated mean of raw samples, inputs must be quiet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dc_state_r <= DC_IDLE;
      dctrig_r <= emu_pkg::RST_BYTE;
      dc_tmr_r <= 32'h00000000;
      dc_cnt_r <= '0;
    end else begin
      unique case (dc_state_r)
        DC_IDLE: begin
          if (wr_ok && reg_addr == emu_pkg::A_AUTO_DC_TRIGGER) begin
            dctrig_r <= reg_wdata[7:0];
            if (reg_wdata[7:0] == emu_pkg::DC_START) begin
              dc_state_r <= DC_SUM;
              dc_tmr_r <= 32'h00000000;
              dc_cnt_r <= '0;
            end
          end
        end
        DC_SUM: begin
          dc_tmr_r <= dc_tmr_r + 32'h00000001;
          if (sample_valid) begin
            dc_cnt_r <= dc_cnt_r + 1'b1;
          end
          if (dc_cnt_r[emu_pkg::DC_LOG2]) begin
            dc_state_r <= DC_WAIT;
          end
        end
        DC_WAIT: begin
          if (dc_tmr_r >= AUTO_DC_TRIGGER_CYCLES - 1) begin
            dc_state_r <= DC_IDLE;
            dctrig_r <= emu_pkg::RST_BYTE;
          end else begin
            dc_tmr_r <= dc_tmr_r + 32'h00000001;
          end
        end
        default: dc_state_r <= DC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        off_r[i] <= emu_pkg::RST_WORD;
        dc_sum_r[i] <= 32'sh00000000;
      end
    end else if (dc_state_r == DC_SUM) begin
      for (int i = 0; i < 3; i++) begin
        if (dc_cnt_r[emu_pkg::DC_LOG2]) begin
          off_r[i] <= 16'(-(dc_sum_r[i] >>> emu_pkg::DC_LOG2));
        end else if (sample_valid) begin
          dc_sum_r[i] <= dc_sum_r[i] + 32'($signed(raw_a[i]));
        end
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        dc_sum_r[i] <= 32'sh00000000;
      end
      // writes are dropped while the trigger still reads one
      if (wr_ok && dctrig_r != emu_pkg::DC_START) begin
        if (reg_addr == emu_pkg::A_OFF_I1) off_r[0] <= reg_wdata;
        if (reg_addr == emu_pkg::A_OFF_I2) off_r[1] <= reg_wdata;
        if (reg_addr == emu_pkg::A_OFF_U) off_r[2] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // pulse generators and energy totals
  // ----------------------------------------------------------------
  pulse_if pif[3] ();

  for (genvar g = 0; g < 3; g++) begin : g_pulse
    assign pif[g].ovf = ovf_valid[g];
    assign pif[g].ovf_neg = ovf_neg[g];
    assign pif[g].gate = gate[g];
    assign pif[g].hf = hf_r;
    assign pif[g].width_sel = adcctl_r[emu_pkg::B_AD_CFP +: 2];
    assign pif[g].polarity = filt_r[emu_pkg::B_FI_POL];
    assign pif[g].cnt_wr = wr_ok &&
      reg_addr == emu_pkg::A_CNT_P + 8'(g);
    assign pif[g].cnt_wdata = reg_wdata;
    pulse_gen #(.WIDTH_CYCLES(PULSE_CYCLES)) u_gen (
      .sys_clk(sys_clk),
      .rst(rst),
      .p(pif[g])
    );
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        energy_r[g] <= 24'h000000;
      end else if (pif[g].fire) begin
        energy_r[g] <= energy_r[g] + 24'h000001;
      end
    end
  end

  assign pif[0].mode = mode_r[emu_pkg::B_MO_ACTIVE_ACCUMULATE_MODE +: 2];
  assign pif[1].mode = mode_r[emu_pkg::B_MO_REACTIVE_ACCUMULATE_MODE +: 2];
  assign pif[2].mode = emu_pkg::ACC_POS;
  assign active_pulse_out = pif[0].pin;
  assign reactive_pulse_out = pif[1].pin;
  assign apparent_pulse_out = pif[2].pin;

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_r <= 4'h0;
    end else begin
      status_r[emu_pkg::B_ST_NOP] <= abs_p < {8'h00, start_r};
      status_r[emu_pkg::B_ST_NOQ] <= abs_q < {8'h00, start_r};
      if (pif[0].fire) begin
        status_r[emu_pkg::B_ST_ACTIVE_NEGATIVE_FLAG] <= pif[0].fire_neg;
      end
      if (pif[1].fire) begin
        status_r[emu_pkg::B_ST_REACTIVE_NEGATIVE_FLAG] <= pif[1].fire_neg;
      end
    end
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_v_r <= 1'b0;
      u_neg_r <= 1'b0;
    end else begin
      samp_v_r <= sample_valid;
      if (samp_v_r) begin
        u_neg_r <= samp_w[2][15];
      end
    end
  end

  assign zx_ev = samp_v_r && (mode_r[emu_pkg::B_MO_ZXD] ?
    (!u_neg_r && samp_w[2][15]) : (u_neg_r && !samp_w[2][15]));

  always_comb begin
    ev_set = 8'h00;
    ev_set[emu_pkg::B_EV_P] = pif[0].fire;
    ev_set[emu_pkg::B_EV_Q] = pif[1].fire;
    ev_set[emu_pkg::B_EV_S] = pif[2].fire;
    ev_set[emu_pkg::B_EV_SPL] = samp_v_r;
    ev_set[emu_pkg::B_EV_ZX] = zx_ev;
    ev_nxt = ev_flag_r;
    if (wr_ok && reg_addr == emu_pkg::A_EV_FLAG) begin
      ev_nxt = ev_nxt & ~reg_wdata[7:0];
    end
    // a set in the clearing cycle wins
    ev_nxt = ev_nxt | (ev_set & ev_en_r);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_flag_r <= emu_pkg::RST_BYTE;
      irq <= 1'b0;
    end else begin
      ev_flag_r <= ev_nxt;
      irq <= |ev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 24'h000000;
    unique case (reg_addr)
      emu_pkg::A_CURRENT1_SAMPLE_WORD: rd_nxt = {8'h00, samp_w[0]};
      emu_pkg::A_CURRENT2_SAMPLE_WORD: rd_nxt = {8'h00, samp_w[1]};
      emu_pkg::A_SPL_U: rd_nxt = {8'h00, samp_w[2]};
      emu_pkg::A_EN_P: rd_nxt = energy_r[0];
      emu_pkg::A_EN_Q: rd_nxt = energy_r[1];
      emu_pkg::A_EN_S: rd_nxt = energy_r[2];
      emu_pkg::A_STATUS: rd_nxt = {20'h00000, status_r};
      emu_pkg::A_CURRENT2_GAIN_TRIM: rd_nxt = {8'h00, current2_gain_trim};
      emu_pkg::A_OFF_I1: rd_nxt = {8'h00, off_r[0]};
      emu_pkg::A_OFF_I2: rd_nxt = {8'h00, off_r[1]};
      emu_pkg::A_OFF_U: rd_nxt = {8'h00, off_r[2]};
      emu_pkg::A_START: rd_nxt = {8'h00, start_r};
      emu_pkg::A_PULSE_DIVIDER_CONSTANT: rd_nxt = {8'h00, hf_r};
      emu_pkg::A_RATIO: rd_nxt = {8'h00, ratio_r};
      emu_pkg::A_CHCTL: rd_nxt = {16'h0000, conv_on_r, theft_detected_r, gt_r,
        sel_r, sum_r, 3'h0};
      emu_pkg::A_FILT: rd_nxt = {16'h0000, filt_r};
      emu_pkg::A_MODE: rd_nxt = {16'h0000, mode_r};
      emu_pkg::A_AUTO_DC_TRIGGER: rd_nxt = {16'h0000, dctrig_r};
      emu_pkg::A_CNT_P: rd_nxt = {8'h00, pif[0].cnt};
      emu_pkg::A_CNT_Q: rd_nxt = {8'h00, pif[1].cnt};
      emu_pkg::A_CNT_S: rd_nxt = {8'h00, pif[2].cnt};
      emu_pkg::A_ADCCTL: rd_nxt = {16'h0000, adcctl_r};
      emu_pkg::A_MINCUR: rd_nxt = {8'h00, mincur_r};
      emu_pkg::A_EV_EN: rd_nxt = {16'h0000, ev_en_r};
      emu_pkg::A_EV_FLAG: rd_nxt = {16'h0000, ev_flag_r};
      default: rd_nxt = 24'h000000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 24'h000000;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end
endmodule

// file: hw/emu_pkg.sv
// constants for the metering pulse back end
// ----------------------------------------------------------------
// Overview of operation
// - pulses are blocked when the run bit is clear or power sits below threshold
// - status shows live no-load bits for active and reactive power
// - negative-power bits refresh together with the matching pulse
// - channel comes from the select bit, or from tamper logic in auto mode
// - current-sum bit makes the front end use both current channels
// - tamper when channel difference reaches ratio threshold, 0x10 meaning 6.25%
// - both currents under the minimum current force channel 1 in auto mode
// - theft bit set on excess difference; greater bit 0 when channel 1 larger
// - auto mode makes select and sum bits read-only; select shows auto choice
// - filter-bypass bit 0 keeps the high-pass filter, 1 bypasses it
// - bypassed channels are corrected by their offset register
// - writing 0x01 to the trigger starts offset calibration, cleared to 0 at end
// - offset writes are ignored while calibration runs
// - calibration lasts about 0.6 s, scaled to the clock
// - active and reactive accumulate positive, absolute or algebraic, each own field
// - fast counters count overflows; reaching divider emits pulse, energy plus one
// - polarity bit 0 gives active-high pulses, 1 active-low
// - pulse width nominal 90 ms, adjusted by a two-bit select
// - periods below twice the selected pulse width (180 ms at select 0) give 50 percent duty
// - pulse events and sample updates raise event requests
// - zero-cross event on rising voltage when direction bit 0, falling when 1
// - five events share one flag register, write 1 clears a flag
// - a flag is set only when its enable bit is set
// ----------------------------------------------------------------
package emu_pkg;
  // register offsets
  localparam logic [7:0] A_CURRENT1_SAMPLE_WORD = 8'h00;
  localparam logic [7:0] A_CURRENT2_SAMPLE_WORD = 8'h01;
  localparam logic [7:0] A_SPL_U = 8'h02;
  localparam logic [7:0] A_EN_P = 8'h0D;
  localparam logic [7:0] A_EN_Q = 8'h0E;
  localparam logic [7:0] A_EN_S = 8'h0F;
  localparam logic [7:0] A_STATUS = 8'h40;
  localparam logic [7:0] A_CURRENT2_GAIN_TRIM = 8'h4A;
  localparam logic [7:0] A_OFF_I1 = 8'h4B;
  localparam logic [7:0] A_OFF_I2 = 8'h4C;
  localparam logic [7:0] A_OFF_U = 8'h4D;
  localparam logic [7:0] A_START = 8'h4E;
  localparam logic [7:0] A_PULSE_DIVIDER_CONSTANT = 8'h4F;
  localparam logic [7:0] A_RATIO = 8'h50;
  localparam logic [7:0] A_CHCTL = 8'h51;
  localparam logic [7:0] A_FILT = 8'h52;
  localparam logic [7:0] A_MODE = 8'h53;
  localparam logic [7:0] A_AUTO_DC_TRIGGER = 8'h54;
  localparam logic [7:0] A_CNT_P = 8'h55;
  localparam logic [7:0] A_CNT_Q = 8'h56;
  localparam logic [7:0] A_CNT_S = 8'h57;
  localparam logic [7:0] A_ADCCTL = 8'h58;
  localparam logic [7:0] A_MINCUR = 8'h59;
  localparam logic [7:0] A_EV_EN = 8'hA9;
  localparam logic [7:0] A_EV_FLAG = 8'hB1;
  // field positions
  localparam int B_ST_NOP = 0;
  localparam int B_ST_NOQ = 1;
  localparam int B_ST_ACTIVE_NEGATIVE_FLAG = 2;
  localparam int B_ST_REACTIVE_NEGATIVE_FLAG = 3;
  localparam int B_CH_CONV = 7;
  localparam int B_CH_THEFT_DETECTED = 6;
  localparam int B_CH_GT = 5;
  localparam int B_CH_SEL = 4;
  localparam int B_CH_SUM = 3;
  localparam int B_FI_POL = 6;
  localparam int B_FI_AUTO = 5;
  localparam int B_MO_ZXD = 3;
  localparam int B_MO_ACTIVE_ACCUMULATE_MODE = 4;
  localparam int B_MO_REACTIVE_ACCUMULATE_MODE = 6;
  localparam int B_AD_CFP = 6;
  localparam int B_EV_LOW = 3;
  localparam int B_EV_ZX = 3;
  localparam int B_EV_SPL = 4;
  localparam int B_EV_S = 5;
  localparam int B_EV_Q = 6;
  localparam int B_EV_P = 7;
  // reset values and calibration start code
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] DC_START = 8'h01;
  // accumulation modes
  localparam logic [1:0] ACC_POS = 2'h0;
  localparam logic [1:0] ACC_ABS = 2'h1;
  localparam logic [1:0] ACC_ALG = 2'h2;
  // calibration averages 2**DC_LOG2 samples
  localparam int DC_LOG2 = 10;
  localparam int HPF_SHIFT = 8;
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_MS = 90;
  localparam int DC_MS = 600;
  localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
  localparam int DC_CYC = DC_MS * CLK_KHZ;
endpackage

// file: hw/pulse_if.sv
// link between the top and one pulse generator
`timescale 1ns/100ps
interface pulse_if;
  logic ovf;
  logic ovf_neg;
  logic gate;
  logic [1:0] mode;
  logic [15:0] hf;
  logic [1:0] width_sel;
  logic polarity;
  logic cnt_wr;
  logic [15:0] cnt_wdata;
  logic [15:0] cnt;
  logic fire;
  logic fire_neg;
  logic pin;
  modport gen(input ovf, ovf_neg, gate, mode, hf, width_sel, polarity,
    cnt_wr, cnt_wdata, output cnt, fire, fire_neg, pin);
  modport ctl(output ovf, ovf_neg, gate, mode, hf, width_sel, polarity,
    cnt_wr, cnt_wdata, input cnt, fire, fire_neg, pin);
endinterface

// file: hw/pulse_gen.sv
// fast pulse counter and pulse shaper for one energy quantity
`timescale 1ns/100ps
module pulse_gen #(
  parameter int unsigned WIDTH_CYCLES = emu_pkg::PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  pulse_if.gen p
);
  logic [15:0] delta;
  logic [15:0] cnt_nxt;
  logic [15:0] mag;
  logic hit;
  logic [31:0] w;
  logic [31:0] per_r;
  logic [31:0] hold_r;
  logic [31:0] hold_nxt;

  always_comb begin
    delta = 16'h0000;
    if (p.ovf && p.gate) begin
      unique case (p.mode)
        emu_pkg::ACC_ABS: delta = 16'h0001;
        emu_pkg::ACC_ALG: delta = p.ovf_neg ? 16'hFFFF : 16'h0001;
        default: delta = p.ovf_neg ? 16'h0000 : 16'h0001;
      endcase
    end
    cnt_nxt = p.cnt + delta;
    mag = cnt_nxt[15] ? 16'(-cnt_nxt) : cnt_nxt;
    hit = p.ovf && p.gate && (mag >= p.hf);
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p.cnt <= emu_pkg::RST_WORD;
    end else if (p.cnt_wr) begin
      p.cnt <= p.cnt_wdata;
    end else if (hit) begin
      p.cnt <= cnt_nxt[15] ? cnt_nxt + p.hf : cnt_nxt - p.hf;
    end else begin
      p.cnt <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p.fire <= 1'b0;
      p.fire_neg <= 1'b0;
    end else begin
      p.fire <= hit;
      p.fire_neg <= hit & cnt_nxt[15];
    end
  end

  // ----------------------------------------------------------------
  // shaper
  // ----------------------------------------------------------------
  // a fresh pulse restarts the shaper even mid-pulse, merging into the pulse still running
  assign w = WIDTH_CYCLES >> p.width_sel;

  always_comb begin
    hold_nxt = hold_r;
    if (hit) begin
      if (per_r < {w[30:0], 1'b0}) begin
        hold_nxt = (per_r > 32'h00000001) ? per_r >> 1 : 32'h00000001;
      end else begin
        hold_nxt = (w != 32'h00000000) ? w : 32'h00000001;
      end
    end else if (hold_r != 32'h00000000) begin
      hold_nxt = hold_r - 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_r <= 32'hFFFFFFFF;
      hold_r <= 32'h00000000;
    end else begin
      if (hit) begin
        per_r <= 32'h00000001;
      end else if (per_r != 32'hFFFFFFFF) begin
        per_r <= per_r + 32'h00000001;
      end
      hold_r <= hold_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p.pin <= 1'b0;
    end else begin
      p.pin <= p.polarity ^ (hold_nxt != 32'h00000000);
    end
  end
endmodule

// file: verif/emu_properties.sv
// register side assertions for the metering back end
`timescale 1ns/100ps
module emu_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic irq,
  input wire logic current_channel_out,
  input wire logic current_sum_out,
  input wire logic second_current_converter_on,
  input wire logic [15:0] current2_gain_trim,
  input wire logic [2:0] filter_bypass_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic auto_r;
  logic w51;
  assign w51 = reg_wr && reg_addr == 8'h51;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) auto_r <= 1'b0;
    else if (reg_wr && reg_addr == 8'h52) auto_r <= reg_wdata[5];
  bypass_follow_a:
    assert property (reg_wr && reg_addr == 8'h52 |=> ##1
      filter_bypass_out == $past(reg_wdata[2:0], 2)) else $error("bypass");
  manual_select_a:
    assert property (w51 && !auto_r |=> ##1 current_channel_out ==
      $past(reg_wdata[4], 2) && current_sum_out == $past(reg_wdata[3], 2))
      else $error("manual select");
  sum_locked_a:
    assert property (w51 && auto_r |=> ##1 $stable(current_sum_out))
      else $error("sum bit not locked");
  conv_follow_a:
    assert property (w51 |=> ##1 second_current_converter_on ==
      $past(reg_wdata[7], 2)) else $error("converter bit");
  gain_follow_a:
    assert property (reg_wr && reg_addr == 8'h4A |=>
      current2_gain_trim == $past(reg_wdata)) else $error("gain trim");
  irq_matches_a:
    assert property ($past(reg_addr) == 8'hB1 && !$past(rst) |->
      (|reg_rdata[7:3]) == $past(irq)) else $error("irq vs flags");
  flag_low_zero_a:
    assert property ($past(reg_addr) == 8'hB1 |-> reg_rdata[2:0] == 3'h0)
      else $error("flag low bits");
  unmapped_zero_a:
    assert property ($past(reg_addr) == 8'h30 |-> reg_rdata == 24'h0)
      else $error("unmapped read");
endmodule
bind energy_meter_pulse_backend emu_properties u_emu_properties (
  .sys_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .irq,
  .current_channel_out, .current_sum_out, .second_current_converter_on,
  .current2_gain_trim, .filter_bypass_out);

// file: verif/host_model.sv
// host processor model issuing register writes and reads
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  input wire logic [23:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // flag clears go through here as ordinary writes of ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask
endmodule

// file: verif/tb_energy_meter_pulse_backend.sv
// self-checking bench for the metering back end
`timescale 1ns/100ps
module tb_energy_meter_pulse_backend;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [23:0] reg_rdata, v;
  logic sample_valid = 1'b0;
  logic [23:0] power_p = 24'h000200;
  logic [23:0] rms_i1 = 24'h000100;
  logic [23:0] rms_i2 = 24'h000112;
  logic [2:0] ovf_valid = 3'h0;
  logic pin_p, pin_q, irq;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 sys_clk = ~sys_clk;
  host_model u_host_model (.sys_clk, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata);
  energy_meter_pulse_backend #(.PULSE_CYCLES(20), .AUTO_DC_TRIGGER_CYCLES(1200))
    u_energy_meter_pulse_backend (.sys_clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .raw_i1(16'h0005), .raw_i2(16'h0000),
    .raw_u(16'h0000), .sample_valid, .rms_i1, .rms_i2,
    .power_p, .power_q(power_p), .ovf_valid, .ovf_neg(3'h0),
    .active_pulse_out(pin_p), .reactive_pulse_out(pin_q),
    .apparent_pulse_out(), .irq, .current_channel_out(),
    .current_sum_out(), .second_current_converter_on(),
    .current2_gain_trim(), .filter_bypass_out());
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch value exp %h got %h", e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    u_host_model.rd(a, v);
    chk(e, v);
  endtask
  task automatic hit(input int k);
    repeat (2) begin
      @(posedge sys_clk);
      #1 ovf_valid[k] = 1'b1;
      @(posedge sys_clk);
      #1 ovf_valid[k] = 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    rchk(8'hB1, 24'h0);
    u_host_model.wr(8'h4F, 16'h0002);
    u_host_model.wr(8'h53, 16'h0005);
    u_host_model.wr(8'hA9, 16'h00E0);
    hit(1);
    hit(0);
    chk(1, pin_p);
    chk(0, pin_q);
    rchk(8'h0D, 24'h1);
    rchk(8'h56, 24'h0);
    rchk(8'hB1, 24'h80);
    chk(1, irq);
    u_host_model.wr(8'hB1, 16'h0080);
    rchk(8'hB1, 24'h0);
    u_host_model.wr(8'h4E, 16'h0300);
    rchk(8'h40, 24'h3);
    hit(0);
    rchk(8'h0D, 24'h1);
    $display("pulse and gate test done");
    u_host_model.wr(8'h51, 16'h0098);
    u_host_model.wr(8'h4A, 16'h1234);
    u_host_model.wr(8'h52, 16'h0027);
    u_host_model.wr(8'h51, 16'h0000);
    u_host_model.wr(8'h50, 16'h0010);
    rchk(8'h51, 24'h78);
    u_host_model.wr(8'h59, 16'h0200);
    rchk(8'h51, 24'h28);
    u_host_model.wr(8'h52, 16'h0040);
    @(posedge sys_clk);
    #1 chk(1, pin_p);
    rchk(8'h30, 24'h0);
    sample_valid = 1'b1;
    u_host_model.wr(8'h54, 16'h0001);
    rchk(8'h54, 24'h1);
    u_host_model.wr(8'h4B, 16'h1234);
    repeat (1250) @(posedge sys_clk);
    rchk(8'h54, 24'h0);
    u_host_model.rd(8'h4B, v);
    chk(16'hFFFB, v[15:0]);
    $display("channel and offset test done");
    wrap_up();
  end
endmodule
